/* pkg/cpas_map.svh */
// constants of the control port front end: addresses, reset values, sizes
`ifndef CPAS_MAP_SVH
`define CPAS_MAP_SVH

// 8-bit write form of the lowest strapped address
`define CPAS_ADDR_BASE     8'h70
// 8-bit write form of the broadcast address
`define CPAS_GLOBAL_ADDR   8'h80
// local address held until the first strap capture
`define CPAS_ADDR_RST      7'h38
`define CPAS_CSUM_RST      8'h00
`define CPAS_BYTE_LAST     4'h8
`define CPAS_SPI_LAST      3'h7
// strap code width: eight addresses
`define CPAS_CODE_W        3

`endif

/* pkg/cpas_pkg.sv */
// types of the control port front end
package cpas_pkg;

  // gray coded along addr -> ack -> write
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_ACK  = 3'h3,
    I2C_WR   = 3'h2,
    I2C_RD   = 3'h6,
    I2C_RACK = 3'h7,
    I2C_SKIP = 3'h5
  } cpas_i2c_e;

  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_d;
    logic       sda_m;
    logic       sda_s;
    logic       sda_d;
    logic       sdz_m;
    logic       sdz_s;
    logic       sdz_d;
    logic       cs_m;
    logic       cs_s;
    logic       sck_m;
    logic       sck_s;
    logic       mosi_m;
    logic       mosi_s;
    logic [2:0] code_m;
    logic [2:0] code_s;
    logic       mode_m;
    logic       mode_s;
    cpas_i2c_e  state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic       rnw;
    logic       ack_ok;
    logic [6:0] local_addr;
    logic       spi_mode;
    logic [7:0] csum;
    logic       sda_oe;
    logic [7:0] wr_data;
    logic       wr_valid;
  } cpas_top_s;

  typedef struct packed {
    logic       sck_d;
    logic [2:0] txcnt;
    logic [2:0] rxcnt;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic       miso;
    logic       miso_oe;
    logic [7:0] rx_data;
    logic       rx_valid;
  } cpas_spi_s;

endpackage

/* pkg/cpas_spi_if.sv */
// link between the front end and its spi target
`timescale 1ns/100ps
interface cpas_spi_if;
  logic       sck;
  logic       mosi;
  logic       cs_n;
  logic [7:0] tx_data;
  logic       miso;
  logic       miso_oe;
  logic [7:0] rx_data;
  logic       rx_valid;

  modport ctl (
    output sck,
    output mosi,
    output cs_n,
    output tx_data,
    input  miso,
    input  miso_oe,
    input  rx_data,
    input  rx_valid
  );

  modport tgt (
    input  sck,
    input  mosi,
    input  cs_n,
    input  tx_data,
    output miso,
    output miso_oe,
    output rx_data,
    output rx_valid
  );
endinterface

/* verilog/cpas_spi.sv */
// spi target, clock idle low, second edge phase, msb first
`include "cpas_map.svh"
`timescale 1ns/100ps
module cpas_spi (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // synchronised link
  cpas_spi_if.tgt  bus
);

  cpas_pkg::cpas_spi_s r;
  cpas_pkg::cpas_spi_s s;

  always_comb begin
    s = r;
    s.rx_valid = 1'b0;
    s.sck_d = bus.sck;
    if (bus.cs_n) begin
      // deselect drops any half frame
      s.txcnt = 3'h0;                                             // RULE11
      s.rxcnt = 3'h0;                                             // RULE11
      s.miso_oe = 1'b0;                                           // RULE11
    end else if (bus.sck && !r.sck_d) begin
      // launch on rising edge
      s.miso_oe = 1'b1;
      if (r.txcnt == 3'h0) begin
        s.miso = bus.tx_data[7];                                  // RULE10
        s.txsh = {bus.tx_data[6:0], 1'b0};
      end else begin
        s.miso = r.txsh[7];                                       // RULE10
        s.txsh = {r.txsh[6:0], 1'b0};
      end
      s.txcnt = r.txcnt + 3'h1;
    end else if (!bus.sck && r.sck_d) begin
      // capture on falling edge
      s.rxsh = {r.rxsh[6:0], bus.mosi};                           // RULE10
      s.rxcnt = r.rxcnt + 3'h1;
      if (r.rxcnt == `CPAS_SPI_LAST) begin
        s.rx_data = {r.rxsh[6:0], bus.mosi};
        s.rx_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign bus.miso     = r.miso;
  assign bus.miso_oe  = r.miso_oe;
  assign bus.rx_data  = r.rx_data;
  assign bus.rx_valid = r.rx_valid;

endmodule

/* verilog/cpas_top.sv */
// control port front end: strap decode, i2c target with checksum, spi target
//
// Behaviour
// RULE1 - a grounded interface strap picks i2c, a resistor to ground picks spi.
// RULE2 - the address strap code selects one of eight addresses 0x70..0x7E.
// RULE3 - with global enable high the broadcast address 0x80 is also accepted.
// RULE4 - with global enable low only the strapped local address answers.
// RULE5 - the host ignores acknowledge during broadcast writes to many targets.
// RULE6 - every received write byte adds into a readable running checksum.
// RULE7 - the address strap is sampled when shutdown is released.
// RULE8 - a redetect request samples the address strap again.
// RULE9 - the spi host runs with clock idle low and second-edge phase.
// RULE10 - spi input is captured on sck falling, output launched on rising.
// RULE11 - raising chip select aborts the frame, floats miso, clears counts.
`include "cpas_map.svh"
`timescale 1ns/100ps
module cpas_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // straps, resolved to logic levels by the pad comparators
  input  wire logic       mode_strap_res,
  input  wire logic [2:0] addr_strap_code,
  input  wire logic       shutdown_release_pin,
  // control bits
  input  wire logic       global_addr_enable,
  input  wire logic       addr_redetect,
  input  wire logic       checksum_clear,
  input  wire logic [7:0] read_data,
  input  wire logic [7:0] spi_tx_data,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // spi pins
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       chip_select_n,
  output logic            miso_o,
  output logic            miso_oe,
  // status
  output logic            spi_selected,
  output logic [6:0]      local_addr,
  output logic [7:0]      bus_write_checksum,
  output logic [7:0]      wr_data,
  output logic            wr_valid,
  output logic [7:0]      spi_rx_data,
  output logic            spi_rx_valid
);

  // ------------------------------------------------------------
  // address helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] strap_addr(input logic [2:0] code);
    logic [7:0] base;
    base = `CPAS_ADDR_BASE;
    strap_addr = base[7:1] + {4'h0, code};                        // RULE2
  endfunction

  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [6:0] loc,
                                    input logic       glb_en);
    logic [7:0] g;
    g = `CPAS_GLOBAL_ADDR;
    // broadcast needs the enable; local always answers
    addr_hit = (b[7:1] == loc) || (glb_en && (b[7:1] == g[7:1])); // RULE3 RULE4
  endfunction

  cpas_pkg::cpas_top_s r;
  cpas_pkg::cpas_top_s s;

  cpas_spi_if spi_bus ();

  cpas_spi cpas_spi_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (spi_bus)
  );

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic awake_c;

  // ------------------------------------------------------------
  // state update
  // ------------------------------------------------------------
  always_comb begin
    s = r;
    s.wr_valid = 1'b0;
    // two-stage synchronisers for every pin
    s.scl_m  = scl_i;
    s.scl_s  = r.scl_m;
    s.scl_d  = r.scl_s;
    s.sda_m  = sda_i;
    s.sda_s  = r.sda_m;
    s.sda_d  = r.sda_s;
    s.sdz_m  = shutdown_release_pin;
    s.sdz_s  = r.sdz_m;
    s.sdz_d  = r.sdz_s;
    s.cs_m   = chip_select_n;
    s.cs_s   = r.cs_m;
    s.sck_m  = sck_i;
    s.sck_s  = r.sck_m;
    s.mosi_m = mosi_i;
    s.mosi_s = r.mosi_m;
    s.code_m = addr_strap_code;
    s.code_s = r.code_m;
    s.mode_m = mode_strap_res;
    s.mode_s = r.mode_m;

    start_c = r.scl_s && r.scl_d && r.sda_d && !r.sda_s;
    stop_c  = r.scl_s && r.scl_d && !r.sda_d && r.sda_s;
    rise_c  = r.scl_s && !r.scl_d;
    fall_c  = !r.scl_s && r.scl_d;
    awake_c = r.sdz_s && !r.spi_mode;

    // straps caught on shutdown release
    if (r.sdz_s && !r.sdz_d) begin
      s.local_addr = strap_addr(r.code_s);                        // RULE7
      s.spi_mode   = r.mode_s;                                    // RULE1
    end else if (addr_redetect && r.sdz_s) begin
      s.local_addr = strap_addr(r.code_s);                        // RULE8
    end

    // clear first so a byte in the same cycle still counts
    if (checksum_clear) begin
      s.csum = `CPAS_CSUM_RST;
    end

    if (!awake_c) begin
      s.state  = cpas_pkg::I2C_IDLE;
      s.sda_oe = 1'b0;
    end else if (start_c) begin
      s.state  = cpas_pkg::I2C_ADDR;
      s.bitcnt = 4'h0;
      s.sda_oe = 1'b0;
    end else if (stop_c) begin
      s.state  = cpas_pkg::I2C_IDLE;
      s.sda_oe = 1'b0;
    end else begin
      case (r.state)
        cpas_pkg::I2C_ADDR: begin
          if (rise_c) begin
            s.shreg  = {r.shreg[6:0], r.sda_s};
            s.bitcnt = r.bitcnt + 4'h1;
          end else if (fall_c && r.bitcnt == `CPAS_BYTE_LAST) begin
            if (addr_hit(r.shreg, r.local_addr, global_addr_enable)) begin
              s.state  = cpas_pkg::I2C_ACK;
              s.sda_oe = 1'b1;
              s.rnw    = r.shreg[0];
            end else begin
              s.state = cpas_pkg::I2C_SKIP;
            end
          end
        end
        cpas_pkg::I2C_ACK: begin
          if (fall_c) begin
            s.bitcnt = 4'h0;
            if (r.rnw) begin
              s.state  = cpas_pkg::I2C_RD;
              s.shreg  = read_data;
              s.sda_oe = !read_data[7];
            end else begin
              s.state  = cpas_pkg::I2C_WR;
              s.sda_oe = 1'b0;
            end
          end
        end
        cpas_pkg::I2C_WR: begin
          if (rise_c) begin
            s.shreg  = {r.shreg[6:0], r.sda_s};
            s.bitcnt = r.bitcnt + 4'h1;
          end else if (fall_c && r.bitcnt == `CPAS_BYTE_LAST) begin
            // acknowledge on broadcast too; the host may not trust it
            s.state    = cpas_pkg::I2C_ACK;
            s.sda_oe   = 1'b1;
            s.csum     = s.csum + r.shreg;                        // RULE6
            s.wr_data  = r.shreg;
            s.wr_valid = 1'b1;
          end
        end
        cpas_pkg::I2C_RD: begin
          if (fall_c) begin
            if (r.bitcnt == 4'h7) begin
              s.state  = cpas_pkg::I2C_RACK;
              s.sda_oe = 1'b0;
            end else begin
              s.sda_oe = !r.shreg[6];
              s.shreg  = {r.shreg[6:0], 1'b0};
              s.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        cpas_pkg::I2C_RACK: begin
          if (rise_c) begin
            s.ack_ok = !r.sda_s;
          end else if (fall_c) begin
            s.bitcnt = 4'h0;
            if (r.ack_ok) begin
              s.state  = cpas_pkg::I2C_RD;
              s.shreg  = read_data;
              s.sda_oe = !read_data[7];
            end else begin
              s.state = cpas_pkg::I2C_SKIP;
            end
          end
        end
        default: begin
          s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.local_addr <= `CPAS_ADDR_RST;
      r.csum       <= `CPAS_CSUM_RST;
      r.scl_m      <= 1'b1;
      r.scl_s      <= 1'b1;
      r.scl_d      <= 1'b1;
      r.sda_m      <= 1'b1;
      r.sda_s      <= 1'b1;
      r.sda_d      <= 1'b1;
      r.cs_m       <= 1'b1;
      r.cs_s       <= 1'b1;
    end else begin
      r <= s;
    end
  end

  // ------------------------------------------------------------
  // spi link: held deselected unless strapped for spi and awake
  // ------------------------------------------------------------
  assign spi_bus.sck     = r.sck_s;
  assign spi_bus.mosi    = r.mosi_s;
  assign spi_bus.cs_n    = r.cs_s || !r.spi_mode || !r.sdz_s;     // RULE1
  assign spi_bus.tx_data = spi_tx_data;

  // open drain: only ever pulls low
  assign sda_o              = 1'b0;
  assign sda_oe             = r.sda_oe;
  assign miso_o             = spi_bus.miso;
  assign miso_oe            = spi_bus.miso_oe;
  assign spi_selected       = r.spi_mode;
  assign local_addr         = r.local_addr;
  assign bus_write_checksum = r.csum;
  assign wr_data            = r.wr_data;
  assign wr_valid           = r.wr_valid;
  assign spi_rx_data        = spi_bus.rx_data;
  assign spi_rx_valid       = spi_bus.rx_valid;

endmodule

/* test/cpas_properties.sv */
// checker of the control port front end
`timescale 1ns/100ps
module cpas_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // straps and control
  input wire logic       mode_strap_res,
  input wire logic [2:0] addr_strap_code,
  input wire logic       shutdown_release_pin,
  input wire logic       addr_redetect,
  input wire logic       checksum_clear,
  input wire logic       chip_select_n,
  // outputs
  input wire logic       sda_oe,
  input wire logic       miso_oe,
  input wire logic       spi_selected,
  input wire logic [6:0] local_addr,
  input wire logic [7:0] bus_write_checksum,
  input wire logic [7:0] wr_data,
  input wire logic       wr_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // strap capture steps
  // --------------------------------------------------------------
  sequence s_release;
    $rose(shutdown_release_pin) ##1 (shutdown_release_pin &&
      $stable(addr_strap_code) && $stable(mode_strap_res))[*5];
  endsequence
  sequence s_redet;
    (addr_redetect && shutdown_release_pin) ##1
      ($stable(addr_strap_code) && shutdown_release_pin)[*6];
  endsequence

  a_mode_latch:
    assert property (s_release |-> spi_selected == mode_strap_res)
    else $error("mode strap not latched");
  a_addr_decode:
    assert property (s_release |-> local_addr == {4'h7, addr_strap_code})
    else $error("address strap not decoded");
  a_redet_addr:
    assert property (s_redet |-> local_addr == {4'h7, addr_strap_code})
    else $error("redetect did not update address");
  a_csum_add:
    assert property (wr_valid |-> bus_write_checksum ==
      ($past(checksum_clear) ? wr_data
       : 8'($past(bus_write_checksum) + wr_data)))
    else $error("checksum did not add byte");
  a_csum_clear:
    assert property ($past(checksum_clear) && !wr_valid |->
      bus_write_checksum == 8'h00)
    else $error("checksum not cleared");
  a_csum_hold:
    assert property (!wr_valid && !$past(checksum_clear) |->
      $stable(bus_write_checksum))
    else $error("checksum moved without a byte");
  a_miso_float:
    assert property (chip_select_n[*5] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_i2c_quiet:
    assert property (spi_selected[*4] |-> !sda_oe)
    else $error("sda driven in spi mode");
  a_sdz_quiet:
    assert property ((!shutdown_release_pin)[*5] |-> !sda_oe && !miso_oe)
    else $error("pins driven in shutdown");
endmodule

/* test/cpas_host.sv */
// host controller model on the i2c and spi pins
`timescale 1ns/100ps
module cpas_host (
  // i2c pins
  output logic            scl,
  output logic            sda,
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  // spi pins
  output logic            sck,
  output logic            mosi,
  output logic            cs_n,
  input  wire logic       miso,
  input  wire logic       miso_oe
);
  logic pull_low;

  // open drain line with pull-up; the target drives only its sda_o level
  assign sda = pull_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
    cs_n = 1'b1;
  end

  // --------------------------------------------------------------
  // i2c transfers
  // --------------------------------------------------------------
  task automatic i2c_start();
    pull_low = 1'b0;
    scl = 1'b1;
    #40 pull_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  // ack is only reported, never acted on: broadcast targets collide
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pull_low = !b[i];
      #30 scl = 1'b1;
      #40 scl = 1'b0;
      #10;
    end
    pull_low = 1'b0;
    #30 scl = 1'b1;
    ack = !sda;
    #40 scl = 1'b0;
    #10;
  endtask
  task automatic i2c_stop();
    pull_low = 1'b1;
    #30 scl = 1'b1;
    #30 pull_low = 1'b0;
    #40;
  endtask
  // one read byte msb first, sampled while scl is high
  task automatic i2c_read(output logic [7:0] b);
    pull_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #30 scl = 1'b1;
      b[i] = sda;
      #40 scl = 1'b0;
      #10;
    end
    // sda left high on the ninth clock: not-acknowledge ends the read
    #30 scl = 1'b1;
    #40 scl = 1'b0;
    #10;
  endtask

  // spi frame: nbits below 8 aborts mid-byte
  task automatic spi_frame(input logic [7:0] tx, input int nbits,
                           output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    #100;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck = 1'b1;
      mosi = tx[i];
      #40 rx[i] = miso_oe ? miso : !miso;
      sck = 1'b0;
      #40;
    end
    #60 cs_n = 1'b1;
    mosi = !mosi;
    #200;
  endtask
endmodule

/* test/cpas_top_tb.sv */
// self-checking bench of the control port front end
`timescale 1ns/100ps
module cpas_top_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mode_strap_res = 1'b0;
  logic [2:0]  addr_strap_code = 3'h0;
  logic        shutdown_release_pin = 1'b0;
  logic        global_addr_enable = 1'b0;
  logic        addr_redetect = 1'b0;
  logic        checksum_clear = 1'b0;
  logic [7:0]  read_data = 8'h00;
  logic [7:0]  spi_tx_data = 8'h00;
  logic        scl, sda, sda_o, sda_oe, sck, mosi, cs_n, miso_o, miso_oe;
  logic        spi_selected, wr_valid, spi_rx_valid, ack;
  logic [6:0]  local_addr;
  logic [7:0]  bus_write_checksum, wr_data, spi_rx_data, sum, b, rx;
  logic [31:0] lfsr = 32'h0001_21fa;
  int          num_errors = 0;
  int          check_count = 0;
  int          rx_pulses = 0;

  always #2.5 clk = ~clk;

  // spi byte strobes, counted away from the launching edge
  always @(negedge clk) begin
    if (spi_rx_valid) begin
      rx_pulses++;
    end
  end

  cpas_top cpas_top_i (.clk, .sys_rst, .mode_strap_res, .addr_strap_code,
    .shutdown_release_pin, .global_addr_enable, .addr_redetect,
    .checksum_clear, .read_data, .spi_tx_data, .scl_i(scl), .sda_i(sda),
    .sda_o, .sda_oe, .sck_i(sck), .mosi_i(mosi), .chip_select_n(cs_n),
    .miso_o, .miso_oe, .spi_selected, .local_addr, .bus_write_checksum,
    .wr_data, .wr_valid, .spi_rx_data, .spi_rx_valid);
  cpas_host cpas_host_i (.scl, .sda, .sda_o, .sda_oe, .sck, .mosi, .cs_n,
    .miso(miso_o), .miso_oe);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [6:0] exp_addr(input logic [2:0] c);
    return 7'h38 + {4'h0, c};
  endfunction
  task automatic rnd(output logic [7:0] v);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v = lfsr[7:0];
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic i2c_wr(input logic [7:0] a, d, input logic exp_ack);
    step(1);
    cpas_host_i.i2c_start();
    cpas_host_i.i2c_byte(a, ack);
    check({7'h00, ack}, {7'h00, exp_ack}, "address ack");
    if (exp_ack) begin
      cpas_host_i.i2c_byte(d, ack);
      sum = sum + d;
      check(wr_data, d, "write byte");
    end
    cpas_host_i.i2c_stop();
    check(bus_write_checksum, sum, "checksum");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    sum = 8'h00;
    step(4);
    sys_rst = 1'b0;
    rnd(b);
    addr_strap_code = b[2:0];
    read_data = b;
    step(4);
    shutdown_release_pin = 1'b1;
    step(8);
    check({1'b0, local_addr}, {1'b0, exp_addr(b[2:0])}, "strap");
    check({7'h00, spi_selected}, 8'h00, "i2c mode");
    $display("test strap done");
    for (int c = 0; c < 8; c++) begin
      addr_strap_code = 3'(c);
      step(4);
      addr_redetect = 1'b1;
      step(1);
      addr_redetect = 1'b0;
      step(8);
      check({1'b0, local_addr}, {1'b0, exp_addr(3'(c))}, "redet");
      rnd(b);
      i2c_wr({exp_addr(3'(c)), 1'b0}, b, 1'b1);
      i2c_wr({exp_addr(3'(c + 1)), 1'b0}, b, 1'b0);
    end
    $display("test address done");
    global_addr_enable = 1'b1;
    rnd(b);
    i2c_wr(8'h80, b, 1'b1);
    global_addr_enable = 1'b0;
    i2c_wr(8'h80, b, 1'b0);
    i2c_wr({exp_addr(3'h7), 1'b0}, b, 1'b1);
    checksum_clear = 1'b1;
    step(1);
    checksum_clear = 1'b0;
    step(2);
    sum = 8'h00;
    check(bus_write_checksum, sum, "clear");
    rnd(read_data);
    step(1);
    cpas_host_i.i2c_start();
    cpas_host_i.i2c_byte({exp_addr(3'h7), 1'b1}, ack);
    cpas_host_i.i2c_read(rx);
    cpas_host_i.i2c_stop();
    check({7'h00, ack}, 8'h01, "read ack");
    check(rx, read_data, "read byte");
    check(bus_write_checksum, sum, "read keeps sum");
    $display("test global done");
    shutdown_release_pin = 1'b0;
    mode_strap_res = 1'b1;
    step(6);
    shutdown_release_pin = 1'b1;
    step(8);
    check({7'h00, spi_selected}, 8'h01, "spi mode");
    i2c_wr({exp_addr(3'h7), 1'b0}, b, 1'b0);
    rnd(b);
    cpas_host_i.spi_frame(b, 3, rx);
    check({7'h00, miso_oe}, 8'h00, "miso float");
    check(8'(rx_pulses), 8'h00, "cut frame strobe");
    for (int k = 0; k < 4; k++) begin
      step(1);
      rnd(spi_tx_data);
      rnd(b);
      cpas_host_i.spi_frame(b, 8, rx);
      check(rx, spi_tx_data, "miso byte");
      check(spi_rx_data, b, "mosi byte");
    end
    check(8'(rx_pulses), 8'h04, "rx strobes");
    $display("test spi done");
    summarize();
  end

  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule

bind cpas_top cpas_properties cpas_properties_i (.clk, .sys_rst,
  .mode_strap_res, .addr_strap_code, .shutdown_release_pin,
  .addr_redetect, .checksum_clear, .chip_select_n, .sda_oe, .miso_oe,
  .spi_selected, .local_addr, .bus_write_checksum, .wr_data, .wr_valid);
